//--- include/rsw_pkg.sv
// constants and types shared by the reset-source and watchdog block
package rsw_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int REF_CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 1000000000 / REF_CLK_HZ;
  // clock monitor trips when no bus clock edge arrives within one slow period
  localparam int CLK_SLOW_HZ = 10000;
  localparam int CLK_FAIL_CYC = REF_CLK_HZ / CLK_SLOW_HZ;
  // power-on delay, a least time
  localparam int POR_DELAY_NS = 100000;
  localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // time the block pulls the shared reset line low after a watchdog or clock-monitor reset
  localparam int PIN_DRIVE_NS = 800;
  localparam int PIN_DRIVE_CYC = (PIN_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus clock cycles after reset in which the rate bits may be written
  localparam int E_WINDOW = 64;

  localparam int GAP_W = 12;
  localparam int TIMER_W = 12;
  localparam int ECNT_W = 7;
  localparam logic [GAP_W-1:0] CLK_FAIL_LAST = GAP_W'(CLK_FAIL_CYC - 1);
  localparam logic [TIMER_W-1:0] POR_DELAY_LAST = TIMER_W'(POR_DELAY_CYC - 1);
  localparam logic [TIMER_W-1:0] PIN_DRIVE_LAST = TIMER_W'(PIN_DRIVE_CYC - 1);
  localparam logic [ECNT_W-1:0] E_WINDOW_CNT = ECNT_W'(E_WINDOW);

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  localparam int WD_PRESCALE_DEF = 32768;
  localparam int WD_CNT_W = 21;
  localparam int RATE_SHIFT_STEP = 2;
  localparam logic [7:0] SVC_ARM = 8'h55;
  localparam logic [7:0] SVC_CLEAR = 8'hAA;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SERVICE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h10;

  localparam int CTRL_RATE_LO = 0;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_WD_DIS = 2;
  localparam int CTRL_CLK_EN = 3;
  localparam int CTRL_SPECIAL = 4;

  localparam int STAT_W = 4;
  localparam int ST_WDOG = 0;
  localparam int ST_CLK = 1;
  localparam int ST_EXT = 2;
  localparam int ST_POR = 3;
  localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset sequencer states, one-hot
  typedef enum logic [3:0] {
    RS_POR = 4'h1,
    RS_DRIVE = 4'h2,
    RS_WAIT = 4'h4,
    RS_RUN = 4'h8
  } rsw_rst_state_t;

endpackage

//--- src/rsw_clock_monitor.sv
// bus clock edge detector and lost-clock monitor
module rsw_clock_monitor
  import rsw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic busClk,
  output logic eTick,
  output logic clockFail
);

  logic busClkPrev_reg;
  logic [GAP_W-1:0] gap_reg;

  // ----------------------------------------------------------------
  // edge detect
  // ----------------------------------------------------------------
  // previous bus clock level
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      busClkPrev_reg <= 1'b0;
    else
      busClkPrev_reg <= busClk;
  end

  assign eTick = busClk & ~busClkPrev_reg;

  // ----------------------------------------------------------------
  // gap counter
  // ----------------------------------------------------------------
  // saturating count of reference cycles since the last bus clock edge;
  // any clock faster than the slow limit never reaches the end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      gap_reg <= '0;
    else if (!enable || eTick)
      gap_reg <= '0;
    else if (gap_reg != CLK_FAIL_LAST)
      gap_reg <= gap_reg + 1'b1;
  end

  assign clockFail = enable && (gap_reg == CLK_FAIL_LAST);

endmodule

//--- src/rsw_wdog_counter.sv
// watchdog count with prescaler and selectable extra divide
module rsw_wdog_counter
  import rsw_pkg::*;
#(
  parameter int PRESCALE = WD_PRESCALE_DEF
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic run,
  input wire logic eTick,
  input wire logic [1:0] rateSel,
  output logic timeout,
  output logic [WD_CNT_W-1:0] count
);

  logic [WD_CNT_W-1:0] count_reg;
  logic [WD_CNT_W-1:0] limit;

  // ----------------------------------------------------------------
  // terminal count
  // ----------------------------------------------------------------
  // prescale times 1, 4, 16 or 64, minus one
  always_comb
  begin
    limit = WD_CNT_W'((PRESCALE << (RATE_SHIFT_STEP * int'(rateSel))) - 1);
  end

  // counts bus clock edges; >= guards a rate lowered mid-count
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      count_reg <= '0;
    else if (restart)
      count_reg <= '0;
    else if (run && eTick)
    begin
      if (count_reg >= limit)
        count_reg <= '0;
      else
        count_reg <= count_reg + 1'b1;
    end
  end

  assign timeout = run && eTick && (count_reg >= limit);
  assign count = count_reg;

endmodule

//--- src/rsw_top.sv
// reset source merge, watchdog and clock monitor with an AXI4-Lite register slave
//
// Our own choices: the register addresses and register access over AXI4-Lite.
module rsw_top
  import rsw_pkg::*;
#(
  parameter int WD_PRESCALE = WD_PRESCALE_DEF
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic porDetect,
  input wire logic busClk,
  input wire logic specialMode,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe_n,
  output logic mcuReset,
  output logic irq,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  rsw_rst_state_t state_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic pinLow;
  logic sysReset;
  logic eTick;
  logic clockFail;
  logic wdTimeout;
  logic [WD_CNT_W-1:0] wdCount;

  logic [1:0] rateSel_reg;
  logic wdDisable_reg;
  logic clkCheckEn_reg;
  logic rateLocked_reg;
  logic disLocked_reg;
  logic [ECNT_W-1:0] eCycles_reg;
  logic armed_reg;
  logic wdRestart;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] mask_reg;
  logic [STAT_W-1:0] statusSet;
  logic [STAT_W-1:0] statusClr;

  logic awHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic wHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic doWrite;
  logic doRead;
  logic [ADDR_W-1:0] wrAddr;
  logic [ADDR_W-1:0] rdAddr;
  logic wrCtrl;
  logic wrService;
  logic wrMask;
  logic wrMapped;
  logic rateWritable;
  logic disWritable;
  logic [31:0] rdValue;
  logic rdMapped;

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // the line is an input sampled as synchronous; low means a request
  assign pinLow = ~resetPinIn;

  // power-on delay, pin drive and wait-for-release; a new power-on
  // event restarts the delay from any state
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= RS_POR;
      timer_reg <= '0;
    end
    else if (porDetect)
    begin
      state_reg <= RS_POR;
      timer_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        RS_POR:
        begin
          if (timer_reg == POR_DELAY_LAST)
          begin
            state_reg <= pinLow ? RS_WAIT : RS_RUN;
            timer_reg <= '0;
          end
          else
            timer_reg <= timer_reg + 1'b1;
        end
        RS_DRIVE:
        begin
          if (timer_reg == PIN_DRIVE_LAST)
          begin
            state_reg <= RS_WAIT;
            timer_reg <= '0;
          end
          else
            timer_reg <= timer_reg + 1'b1;
        end
        RS_WAIT:
        begin
          // released line may take a cycle to float back high
          if (!pinLow)
            state_reg <= RS_RUN;
        end
        RS_RUN:
        begin
          if (wdTimeout || clockFail)
          begin
            state_reg <= RS_DRIVE;
            timer_reg <= '0;
          end
        end
      endcase
    end
  end

  // internal reset follows every source; an outside pulse of any length
  // is honoured, longer ones simply stretch the reset
  assign sysReset = (state_reg != RS_RUN) || pinLow;
  assign mcuReset = sysReset;
  // open-drain style: value is always low, only the enable moves
  assign resetPinOut = 1'b0;
  assign resetPinOe_n = (state_reg != RS_DRIVE);

  // ----------------------------------------------------------------
  // clock monitor and watchdog count
  // ----------------------------------------------------------------
  rsw_clock_monitor u_clock_monitor (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(clkCheckEn_reg),
    .busClk(busClk),
    .eTick(eTick),
    .clockFail(clockFail)
  );

  rsw_wdog_counter #(
    .PRESCALE(WD_PRESCALE)
  ) u_wdog_counter (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(wdRestart),
    .run(!wdDisable_reg),
    .eTick(eTick),
    .rateSel(rateSel_reg),
    .timeout(wdTimeout),
    .count(wdCount)
  );

  // ----------------------------------------------------------------
  // bus write channel
  // ----------------------------------------------------------------
  // address and data are held separately so either may arrive first
  assign awready = ~awHeld_reg;
  assign wready = ~wHeld_reg;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign wrAddr = {awAddr_reg[ADDR_W-1:2], 2'b00};
  assign wrCtrl = doWrite && wStrb_reg[0] && (wrAddr == ADDR_CTRL);
  assign wrService = doWrite && wStrb_reg[0] && (wrAddr == ADDR_SERVICE);
  assign wrMask = doWrite && wStrb_reg[0] && (wrAddr == ADDR_MASK);
  assign wrMapped = (wrAddr == ADDR_CTRL) || (wrAddr == ADDR_SERVICE) ||
                    (wrAddr == ADDR_STATUS) || (wrAddr == ADDR_MASK) ||
                    (wrAddr == ADDR_COUNT);

  // write holding registers and response
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && !awHeld_reg)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && !wHeld_reg)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && bready)
        bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // ----------------------------------------------------------------
  // control register with time protection
  // ----------------------------------------------------------------
  // bus clock edges since reset, saturating at the window length
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      eCycles_reg <= '0;
    else if (sysReset)
      eCycles_reg <= '0;
    else if (eTick && (eCycles_reg != E_WINDOW_CNT))
      eCycles_reg <= eCycles_reg + 1'b1;
  end

  assign rateWritable = specialMode || (!rateLocked_reg && (eCycles_reg < E_WINDOW_CNT));
  assign disWritable = specialMode || !disLocked_reg;

  // writes landing during reset are dropped: reset wins
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rateSel_reg <= 2'h0;
      wdDisable_reg <= 1'b0;
      clkCheckEn_reg <= 1'b0;
      rateLocked_reg <= 1'b0;
      disLocked_reg <= 1'b0;
    end
    else if (sysReset)
    begin
      rateSel_reg <= 2'h0;
      wdDisable_reg <= 1'b0;
      clkCheckEn_reg <= 1'b0;
      rateLocked_reg <= 1'b0;
      disLocked_reg <= 1'b0;
    end
    else if (wrCtrl)
    begin
      clkCheckEn_reg <= wData_reg[CTRL_CLK_EN];
      if (rateWritable)
      begin
        rateSel_reg <= {wData_reg[CTRL_RATE_HI], wData_reg[CTRL_RATE_LO]};
        rateLocked_reg <= 1'b1;
      end
      if (disWritable)
      begin
        wdDisable_reg <= wData_reg[CTRL_WD_DIS];
        disLocked_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // service sequence
  // ----------------------------------------------------------------
  // other values leave the arm state alone, so unrelated writes may sit
  // between the two service writes
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      armed_reg <= 1'b0;
    else if (sysReset)
      armed_reg <= 1'b0;
    else if (wrService && (wData_reg[7:0] == SVC_ARM))
      armed_reg <= 1'b1;
    else if (wrService && (wData_reg[7:0] == SVC_CLEAR))
      armed_reg <= 1'b0;
  end

  assign wdRestart = sysReset ||
                     (wrService && armed_reg && (wData_reg[7:0] == SVC_CLEAR));

  // ----------------------------------------------------------------
  // event status and interrupt
  // ----------------------------------------------------------------
  always_comb
  begin
    statusSet = '0;
    statusSet[ST_WDOG] = (state_reg == RS_RUN) && wdTimeout;
    statusSet[ST_CLK] = (state_reg == RS_RUN) && clockFail;
    statusSet[ST_EXT] = (state_reg == RS_RUN) && pinLow;
    statusSet[ST_POR] = porDetect;
  end

  // cleared by reading; a new event in the clearing cycle survives
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      status_reg <= STAT_RESET;
    else
      status_reg <= (status_reg & ~statusClr) | statusSet;
  end

  // mask survives internal resets so the cause can still be signalled
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      mask_reg <= MASK_RESET;
    else if (wrMask)
      mask_reg <= wData_reg[STAT_W-1:0];
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // bus read channel
  // ----------------------------------------------------------------
  assign arready = ~rvalid_reg;
  assign doRead = arvalid && !rvalid_reg;
  assign rdAddr = {araddr[ADDR_W-1:2], 2'b00};
  assign statusClr = (doRead && (rdAddr == ADDR_STATUS)) ? status_reg : '0;

  // read data mux; unused upper bits read zero
  always_comb
  begin
    rdValue = '0;
    rdMapped = 1'b1;
    unique case (rdAddr)
      ADDR_CTRL:
      begin
        rdValue[CTRL_RATE_LO] = rateSel_reg[0];
        rdValue[CTRL_RATE_HI] = rateSel_reg[1];
        rdValue[CTRL_WD_DIS] = wdDisable_reg;
        rdValue[CTRL_CLK_EN] = clkCheckEn_reg;
        rdValue[CTRL_SPECIAL] = specialMode;
      end
      ADDR_SERVICE: rdValue[0] = armed_reg;
      ADDR_STATUS: rdValue[STAT_W-1:0] = status_reg;
      ADDR_MASK: rdValue[STAT_W-1:0] = mask_reg;
      ADDR_COUNT: rdValue[WD_CNT_W-1:0] = wdCount;
      default: rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end
    else if (doRead)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdValue;
      rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && rready)
      rvalid_reg <= 1'b0;
  end

  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;

endmodule

//--- test/rsw_ext_system.sv
// far-side model: outside system on the shared reset line, source of the bus clock
module rsw_ext_system
(
  input wire logic ref_clk,
  input wire logic resetPinOut,
  input wire logic resetPinOe_n,
  input wire logic holdLow,
  input wire logic requestPulse,
  input wire logic clockStop,
  output logic resetPinIn,
  output logic busClk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] divCnt = 3'h0;
  logic [3:0] reqLeft = 4'h0;
  // bus clock at ref/8, well above the monitor limit; frozen when stopped
  always_ff @(posedge ref_clk)
    if (!clockStop)
      divCnt <= divCnt + 3'h1;
  assign busClk = divCnt[2];
  // nine rises so the line is low for at least eight full bus cycles
  always_ff @(posedge ref_clk)
    if (requestPulse)
      reqLeft <= 4'h9;
    else if (!clockStop && divCnt == 3'h3 && reqLeft != 4'h0)
      reqLeft <= reqLeft - 4'h1;
  // wired line with pull-up: any party pulling low wins
  assign resetPinIn = !(holdLow || reqLeft != 4'h0 || (!resetPinOe_n && !resetPinOut));
endmodule

//--- test/rsw_top_properties.sv
// concurrent checks on the ports of the reset-source and watchdog block
module rsw_top_properties
  import rsw_pkg::*;
#(
  parameter int WD_PRESCALE = WD_PRESCALE_DEF
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic resetPinIn,
  input wire logic resetPinOe_n,
  input wire logic mcuReset,
  input wire logic irq,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic [4:0] driveCnt;
  logic [11:0] sinceRel;
  // --------------------------------------------------------------
  // helper counters
  // --------------------------------------------------------------
  // length of the current line drive
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      driveCnt <= 5'h0;
    else
      driveCnt <= resetPinOe_n ? 5'h0 : driveCnt + 5'h1;
  // cycles since release, saturating so it never wraps back into the delay
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      sinceRel <= 12'h0;
    else if (sinceRel != 12'hFFF)
      sinceRel <= sinceRel + 12'h1;
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_pin_low_reset: assert property (!resetPinIn |-> mcuReset)
    else $error("line low but no internal reset");
  a_drive_resets: assert property (!resetPinOe_n |-> mcuReset)
    else $error("line driven without internal reset");
  a_drive_length: assert property ($rose(resetPinOe_n) |-> driveCnt == 5'(PIN_DRIVE_CYC))
    else $error("line drive length wrong");
  a_por_hold: assert property (sinceRel < 12'(POR_DELAY_CYC) |-> mcuReset)
    else $error("left reset before power-on delay");
  a_wr_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write response missing");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  c_line_drive: cover property ($fell(resetPinOe_n));
  c_slverr: cover property (bvalid && bready && bresp == RESP_SLVERR);
  c_irq: cover property ($rose(irq));
endmodule

bind rsw_top rsw_top_properties #(.WD_PRESCALE(WD_PRESCALE)) i_rsw_top_properties (
  .ref_clk(ref_clk), .reset(reset), .resetPinIn(resetPinIn), .resetPinOe_n(resetPinOe_n),
  .mcuReset(mcuReset), .irq(irq), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready));

//--- test/rsw_top_tb.sv
// self-checking bench for the reset-source and watchdog block
module rsw_top_tb
  import rsw_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRE = 4;
  localparam int BUS_DIV = 8;
  localparam int BUS = PRE * BUS_DIV;
  typedef struct {logic [1:0] rate; int cyc;} rsw_row_t;
  // rate code beside the ref cycles from run to line drive
  rsw_row_t rows [4] = '{'{2'h0, BUS}, '{2'h1, BUS * 4}, '{2'h2, BUS * 16}, '{2'h3, BUS * 64}};
  logic ref_clk = 1'b0, reset = 1'b1, porDetect = 1'b0, specialMode = 1'b0, holdLow = 1'b1;
  logic requestPulse = 1'b0, clockStop = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic busClk, resetPinIn, resetPinOut, resetPinOe_n, mcuReset, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  int n_fail = 0, n_compared = 0, n;
  longint t0;

  rsw_top #(.WD_PRESCALE(PRE)) i_rsw_top (.ref_clk(ref_clk), .reset(reset),
    .porDetect(porDetect), .busClk(busClk), .specialMode(specialMode),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOe_n(resetPinOe_n),
    .mcuReset(mcuReset), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  rsw_ext_system i_rsw_ext_system (.ref_clk(ref_clk), .resetPinOut(resetPinOut),
    .resetPinOe_n(resetPinOe_n), .holdLow(holdLow), .requestPulse(requestPulse),
    .clockStop(clockStop), .resetPinIn(resetPinIn), .busClk(busClk));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one AXI4-Lite transfer; each channel drops valid once its ready was seen
  task automatic axi(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {wr, wr, wr, !wr, !wr};
    for (int i = 0; i < 40 && !done; i++)
    begin
      @(posedge ref_clk);
      // only a channel still offered is released, so no signal gets two drives at once
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (arvalid && arready)
        arvalid <= 1'b0;
      done = wr ? bvalid === 1'b1 : rvalid === 1'b1;
      rd = rdata;
      resp = wr ? bresp : rresp;
    end
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    chk(done, 1'b1);
    @(posedge ref_clk);
  endtask
  // bounded waits: until the block drives the line, until it runs
  task automatic to_drive(input int limit);
    for (n = 0; n < limit && resetPinOe_n !== 1'b0; n++)
      @(posedge ref_clk);
  endtask
  task automatic wait_run();
    for (int i = 0; i < 6000 && mcuReset !== 1'b0; i++)
      @(posedge ref_clk);
    chk(mcuReset, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // clock, watchdog, tests
  // --------------------------------------------------------------
  initial
    forever #25 ref_clk = !ref_clk;
  // generous: the whole sequence needs about 16000 cycles
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    $display("[ERR] %0t run timed out", $time);
    report_and_stop();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    chk({resetPinOe_n, mcuReset, irq}, 3'h6);
    reset <= 1'b0;
    axi(1'b0, ADDR_MASK, 32'h0);
    chk(rd, 32'h0);
    axi(1'b1, ADDR_MASK, 32'h1);
    repeat (2100) @(posedge ref_clk);
    chk(mcuReset, 1'b1);
    holdLow <= 1'b0;
    // every rate code; each timeout resets and reopens the write window
    foreach (rows[k])
    begin
      wait_run();
      t0 = $time;
      axi(1'b1, ADDR_CTRL, {30'h0, rows[k].rate});
      to_drive(2200);
      n = int'(($time - t0) / 50);
      chk(n >= rows[k].cyc - 20 && n <= rows[k].cyc + 20, 1'b1);
      repeat (2) @(posedge ref_clk);
      chk({resetPinOe_n, resetPinIn, irq}, 3'h1);
      axi(1'b0, ADDR_STATUS, 32'h0);
      chk({rd[ST_WDOG], irq}, 2'h2);
    end
    // service keeps it alive; a second rate write is ignored
    wait_run();
    axi(1'b1, ADDR_CTRL, 32'h1);
    axi(1'b1, ADDR_CTRL, 32'h3);
    repeat (6)
    begin
      axi(1'b1, ADDR_SERVICE, {24'h0, SVC_ARM});
      axi(1'b0, ADDR_MASK, 32'h0);
      axi(1'b1, ADDR_SERVICE, {24'h0, SVC_CLEAR});
      repeat (40) @(posedge ref_clk);
    end
    chk(mcuReset, 1'b0);
    axi(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    axi(1'b1, ADDR_SERVICE, {24'h0, SVC_CLEAR});
    to_drive(BUS * 4 - 24);
    chk(resetPinOe_n, 1'b0);
    // disable once, then the clock monitor off, quiet and tripping
    wait_run();
    axi(1'b1, ADDR_CTRL, 32'h4);
    axi(1'b1, ADDR_CTRL, 32'h0);
    axi(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h4);
    clockStop <= 1'b1;
    repeat (2500) @(posedge ref_clk);
    chk(mcuReset, 1'b0);
    clockStop <= 1'b0;
    axi(1'b1, ADDR_CTRL, 32'hC);
    repeat (2500) @(posedge ref_clk);
    chk(mcuReset, 1'b0);
    clockStop <= 1'b1;
    to_drive(CLK_FAIL_CYC + 40);
    chk(resetPinOe_n, 1'b0);
    clockStop <= 1'b0;
    // outside request on the line
    wait_run();
    requestPulse <= 1'b1;
    @(posedge ref_clk);
    requestPulse <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(mcuReset, 1'b1);
    wait_run();
    axi(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_EXT:ST_CLK], 2'h3);
    // power-on event restarts the long delay
    wait_run();
    porDetect <= 1'b1;
    @(posedge ref_clk);
    porDetect <= 1'b0;
    repeat (1900) @(posedge ref_clk);
    chk(mcuReset, 1'b1);
    wait_run();
    axi(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[ST_POR], 1'b1);
    // special mode lifts the once-only limits late in the run
    wait_run();
    axi(1'b1, ADDR_CTRL, 32'h4);
    specialMode <= 1'b1;
    repeat (800) @(posedge ref_clk);
    axi(1'b1, ADDR_CTRL, 32'h3);
    chk(resp, RESP_OKAY);
    axi(1'b1, ADDR_CTRL, 32'h6);
    axi(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[4:0], 5'h16);
    // unmapped place
    axi(1'b1, 8'h40, 32'h0);
    chk(resp, RESP_SLVERR);
    axi(1'b0, 8'h40, 32'h0);
    chk({rd[29:0], resp}, {30'h0, RESP_SLVERR});
    report_and_stop();
  end
endmodule
